// ===== logic/rx_cpu_policer_pkg.sv
// Constants, register map and field layout of the receive CPU channel policer
// How it works
// RQ1: Recovery-A bit set: sequence and timestamp record goes to queue A.
// RQ2: Recovery-B bit set: sequence and timestamp record goes to queue B.
// RQ3: Buffer index field selects the host buffer control table entry.
// RQ4: Half-full enable and buffer over half full drive the error alarm.
// RQ5: Bucket fill drains at the programmed rate of bytes per frame.
// RQ6: Rate 1.mm float, 4-bit exponent: 4 kbps times mantissa/8 times 2^exp.
// RQ7: Software never sets rate zero; minimum is mantissa 100, exponent 0001.
// RQ8: Packet discarded when accepting it would push the bucket past maximum.
// RQ9: Maximum fill 0x0000 means 65536 bytes; others are their byte count.
// RQ10: Bucket fill kept in sixty-fourths of a byte and written back.
// RQ11: Software clears the bucket fill to zero when creating the channel.
// RQ12: Accepted packet adds its byte count times sixty-four to the fill.
// RQ13: Frame time of the last packet kept; frame difference sets the drain.
// RQ14: Software clears the initialized bit; first packet sets it.
// RQ15: Every packet reaching the channel increments the packet counter.
// RQ16: Every packet reaching the channel adds UDP length minus 8 to octets.
package rx_cpu_policer_pkg;
  localparam int DATA_W   = 32;
  localparam int ADR_W    = 8;
  localparam int SEL_W    = 4;
  localparam int BYTE_W   = 8;
  localparam int IDX_W    = 12;
  localparam int MANT_W   = 2;
  localparam int EXP_W    = 4;
  localparam int RATE_W   = MANT_W + EXP_W;
  localparam int MAX_W    = 16;
  localparam int FRAC_SH  = 6;
  localparam int FILL_W   = MAX_W + 1 + FRAC_SH;
  localparam int DRAIN_W  = 18;
  localparam int FRAME_W  = 16;
  localparam int LEN_W    = 16;
  localparam int SEQ_W    = 16;
  localparam int TS_W     = 32;
  localparam int IRQ_W    = 3;

  // Register byte offsets
  localparam logic [ADR_W-1:0] OFS_CTRL    = 8'h00;
  localparam logic [ADR_W-1:0] OFS_RATE    = 8'h04;
  localparam logic [ADR_W-1:0] OFS_MAXFILL = 8'h08;
  localparam logic [ADR_W-1:0] OFS_FILL    = 8'h0c;
  localparam logic [ADR_W-1:0] OFS_LASTTS  = 8'h10;
  localparam logic [ADR_W-1:0] OFS_INIT    = 8'h14;
  localparam logic [ADR_W-1:0] OFS_PKTCNT  = 8'h18;
  localparam logic [ADR_W-1:0] OFS_OCTCNT  = 8'h1c;
  localparam logic [ADR_W-1:0] OFS_IRQSTAT = 8'h20;
  localparam logic [ADR_W-1:0] OFS_IRQMASK = 8'h24;

  // Control register fields
  localparam int CTRL_A_BIT   = 0;
  localparam int CTRL_B_BIT   = 1;
  localparam int CTRL_HF_BIT  = 2;
  localparam int CTRL_IDX_LSB = 8;

  // Interrupt status bits
  localparam int IRQ_DROP_BIT = 0;
  localparam int IRQ_HALF_BIT = 1;
  localparam int IRQ_ACC_BIT  = 2;

  localparam logic [LEN_W-1:0]   UDP_HDR_BYTES = 16'h0008;
  localparam logic [MAX_W:0]     BUCKET_FULL   = 17'h10000;
  localparam logic [DATA_W-1:0]  ONE_COUNT     = 32'h0000_0001;
  localparam logic [DATA_W-1:0]  RESET_WORD    = 32'h0000_0000;
endpackage : rx_cpu_policer_pkg

// ===== logic/policer_math.sv
// Leaky bucket arithmetic: rate decode, drain, add and limit test
`timescale 1ns/1ps
module policer_math
  import rx_cpu_policer_pkg::*;
(
  // Bucket state
  input  wire logic [FILL_W-1:0]  fillNow,
  input  wire logic [FRAME_W-1:0] frames,
  // Channel settings
  input  wire logic [MANT_W-1:0]  rateMant,
  input  wire logic [EXP_W-1:0]   rateExp,
  input  wire logic [MAX_W-1:0]   maxBytes,
  // Packet size in bytes
  input  wire logic [LEN_W-1:0]   lenBytes,
  // Results
  output logic      [DRAIN_W-2:0] rate64,
  output logic      [FILL_W-1:0]  drained,
  output logic      [FILL_W-1:0]  fillNext,
  output logic                    overMax
);
  localparam int PROD_W = DRAIN_W - 1 + FRAME_W;

  logic [DRAIN_W-1:0] rateBase;
  logic [DRAIN_W-1:0] rateShift;
  logic [PROD_W-1:0]  drain;
  logic [MAX_W:0]     maxFull;
  logic [FILL_W-1:0]  max64;
  logic [FILL_W:0]    added;
  logic [FILL_W-1:0]  lenFill;

  // Rate in 1/64 byte per frame is {1,mant} shifted by exp, halved
  assign rateBase  = {{(DRAIN_W-MANT_W-1){1'b0}}, 1'b1, rateMant};  // RQ6
  assign rateShift = rateBase << rateExp;  // RQ6
  assign rate64    = rateShift[DRAIN_W-1:1];  // RQ6
  assign drain     = rate64 * frames;  // RQ5
  assign drained   = (drain >= PROD_W'(fillNow)) ? '0
                   : fillNow - drain[FILL_W-1:0];  // RQ5
  assign maxFull   = (maxBytes == '0) ? BUCKET_FULL : {1'b0, maxBytes};  // RQ9
  assign max64     = {maxFull, {FRAC_SH{1'b0}}};  // RQ10
  assign lenFill   = {1'b0, lenBytes, {FRAC_SH{1'b0}}};  // RQ12
  assign added     = {1'b0, drained} + {1'b0, lenFill};  // RQ12
  assign overMax   = added > {1'b0, max64};  // RQ8
  assign fillNext  = overMax ? drained : added[FILL_W-1:0];  // RQ8
endmodule : policer_math

// ===== logic/rx_cpu_channel_policer.sv
// Receive CPU channel: policer, recovery records, counters and Wishbone regs
//
// Decided for this implementation: the address map and the Wishbone register port.
`timescale 1ns/1ps
module rx_cpu_channel_policer
  import rx_cpu_policer_pkg::*;
(
  // Clock and reset
  input  wire logic              clk,
  input  wire logic              rst,
  // Wishbone slave
  input  wire logic              cyc_i,
  input  wire logic              stb_i,
  input  wire logic              we_i,
  input  wire logic [ADR_W-1:0]  adr_i,
  input  wire logic [DATA_W-1:0] dat_i,
  input  wire logic [SEL_W-1:0]  sel_i,
  output logic      [DATA_W-1:0] dat_o,
  output logic                   ack_o,
  // Packet arrival
  input  wire logic              pktValid,
  input  wire logic [LEN_W-1:0]  pktUdpLen,
  input  wire logic [SEQ_W-1:0]  pktSeq,
  input  wire logic [TS_W-1:0]   pktTs,
  // Frame timing
  input  wire logic [FRAME_W-1:0] frameCount,
  // Selected host buffer state
  input  wire logic [LEN_W-1:0]  hostBufLevel,
  input  wire logic [LEN_W-1:0]  hostBufCap,
  // Packet verdict and buffer select
  output logic                   pktAccept,
  output logic                   pktDrop,
  output logic      [IDX_W-1:0]  bufIndex,
  // Clock recovery records
  output logic                   crAValid,
  output logic                   crBValid,
  output logic      [SEQ_W-1:0]  crSeq,
  output logic      [TS_W-1:0]   crTs,
  // Alarms
  output logic                   errorAlarm,
  output logic                   irq
);
  function automatic logic [DATA_W-1:0] mergeBytes(
    input logic [DATA_W-1:0] oldV,
    input logic [DATA_W-1:0] newV,
    input logic [SEL_W-1:0]  sel
  );
    logic [DATA_W-1:0] res;
    res = oldV;
    for (int i = 0; i < SEL_W; i++) begin
      if (sel[i]) begin
        res[i*BYTE_W +: BYTE_W] = newV[i*BYTE_W +: BYTE_W];
      end
    end
    return res;
  endfunction : mergeBytes

  // Register state
  logic [DATA_W-1:0]  ctrl_reg;
  logic [RATE_W-1:0]  rate_reg;
  logic [MAX_W-1:0]   max_reg;
  logic [FILL_W-1:0]  fill_reg;
  logic [FRAME_W-1:0] lastTs_reg;
  logic               init_reg;
  logic [DATA_W-1:0]  pktCnt_reg;
  logic [DATA_W-1:0]  octCnt_reg;
  logic [IRQ_W-1:0]   irqStat_reg;
  logic [IRQ_W-1:0]   irqMask_reg;
  logic               half_reg;

  // Bus decode
  logic              wbReq;
  logic              wrHit;
  logic [DATA_W-1:0] rdData;
  logic [DATA_W-1:0] wrCtrl;
  logic [DATA_W-1:0] wrRate;
  logic [DATA_W-1:0] wrMax;
  logic [DATA_W-1:0] wrFill;
  logic [DATA_W-1:0] wrIrq;
  logic [DATA_W-1:0] wrMask;

  assign wbReq  = cyc_i & stb_i & ~ack_o;
  assign wrHit  = wbReq & we_i;
  assign wrCtrl = mergeBytes(ctrl_reg, dat_i, sel_i);
  assign wrRate = mergeBytes(DATA_W'(rate_reg), dat_i, sel_i);
  assign wrMax  = mergeBytes(DATA_W'(max_reg), dat_i, sel_i);
  assign wrFill = mergeBytes(DATA_W'(fill_reg), dat_i, sel_i);
  assign wrIrq  = mergeBytes(RESET_WORD, dat_i, sel_i);
  assign wrMask = mergeBytes(DATA_W'(irqMask_reg), dat_i, sel_i);
  assign rdData =
      (adr_i == OFS_CTRL)    ? ctrl_reg :
      (adr_i == OFS_RATE)    ? DATA_W'(rate_reg) :
      (adr_i == OFS_MAXFILL) ? DATA_W'(max_reg) :
      (adr_i == OFS_FILL)    ? DATA_W'(fill_reg) :
      (adr_i == OFS_LASTTS)  ? DATA_W'(lastTs_reg) :
      (adr_i == OFS_INIT)    ? DATA_W'(init_reg) :
      (adr_i == OFS_PKTCNT)  ? pktCnt_reg :
      (adr_i == OFS_OCTCNT)  ? octCnt_reg :
      (adr_i == OFS_IRQSTAT) ? DATA_W'(irqStat_reg) :
      (adr_i == OFS_IRQMASK) ? DATA_W'(irqMask_reg) : RESET_WORD;

  logic ctrlMaskWr;
  logic [DATA_W-1:0] ctrlKeep;
  assign ctrlKeep = DATA_W'({{IDX_W{1'b1}},
                             {(CTRL_IDX_LSB-CTRL_HF_BIT-1){1'b0}}, 3'h7});
  assign ctrlMaskWr = wrHit & (adr_i == OFS_CTRL);

  // Channel fields
  logic              selA;
  logic              selB;
  logic              hfEn;
  logic [IDX_W-1:0]  idxField;
  logic [FRAME_W-1:0] frameDelta;
  logic [LEN_W-1:0]  payLen;
  logic [DRAIN_W-2:0] rate64;
  logic [FILL_W-1:0] drained;
  logic [FILL_W-1:0] fillNext;
  logic              overMax;
  logic              halfFull;
  logic              accept;
  logic [IRQ_W-1:0]  irqEvents;

  assign selA     = ctrl_reg[CTRL_A_BIT];
  assign selB     = ctrl_reg[CTRL_B_BIT];
  assign hfEn     = ctrl_reg[CTRL_HF_BIT];
  assign idxField = ctrl_reg[CTRL_IDX_LSB +: IDX_W];  // RQ3
  assign frameDelta = init_reg ? frameCount - lastTs_reg : '0;  // RQ13
  assign payLen   = (pktUdpLen > UDP_HDR_BYTES) ? pktUdpLen - UDP_HDR_BYTES
                  : '0;  // RQ16
  assign accept   = pktValid & ~overMax;  // RQ8
  assign halfFull = hfEn & ({1'b0, hostBufLevel, 1'b0} >
                            {2'b00, hostBufCap});  // RQ4
  assign irqEvents = {accept, halfFull & ~half_reg, pktValid & overMax};

  policer_math u_math (
    .fillNow  (fill_reg),
    .frames   (frameDelta),
    .rateMant (rate_reg[MANT_W-1:0]),
    .rateExp  (rate_reg[RATE_W-1:MANT_W]),
    .maxBytes (max_reg),
    .lenBytes (payLen),
    .rate64   (rate64),
    .drained  (drained),
    .fillNext (fillNext),
    .overMax  (overMax)
  );

  // Bus answer, one cycle after the request
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ack_o <= 1'b0;
      dat_o <= '0;
    end else begin
      ack_o <= wbReq;
      dat_o <= (wbReq & ~we_i) ? rdData : '0;
    end
  end

  // Software settings
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ctrl_reg    <= '0;
      rate_reg    <= '0;
      max_reg     <= '0;
      irqMask_reg <= '0;
    end else if (wrHit) begin
      if (ctrlMaskWr) ctrl_reg <= wrCtrl & ctrlKeep;
      if (adr_i == OFS_RATE) rate_reg <= wrRate[RATE_W-1:0];
      if (adr_i == OFS_MAXFILL) max_reg <= wrMax[MAX_W-1:0];
      if (adr_i == OFS_IRQMASK) irqMask_reg <= wrMask[IRQ_W-1:0];
    end
  end

  // Bucket state, packet wins over a software write
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      fill_reg   <= '0;
      lastTs_reg <= '0;
      init_reg   <= 1'b0;
    end else if (pktValid) begin
      fill_reg   <= fillNext;  // RQ10
      lastTs_reg <= frameCount;  // RQ13
      init_reg   <= 1'b1;  // RQ14
    end else if (wrHit) begin
      if (adr_i == OFS_FILL) fill_reg <= wrFill[FILL_W-1:0];
      if (adr_i == OFS_LASTTS) lastTs_reg <= dat_i[FRAME_W-1:0];
      if (adr_i == OFS_INIT) init_reg <= dat_i[0];
    end
  end

  // Channel counters
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pktCnt_reg <= '0;
      octCnt_reg <= '0;
    end else if (pktValid) begin
      pktCnt_reg <= pktCnt_reg + ONE_COUNT;  // RQ15
      octCnt_reg <= octCnt_reg + DATA_W'(payLen);  // RQ16
    end else if (wrHit) begin
      if (adr_i == OFS_PKTCNT) begin
        pktCnt_reg <= mergeBytes(pktCnt_reg, dat_i, sel_i);
      end
      if (adr_i == OFS_OCTCNT) begin
        octCnt_reg <= mergeBytes(octCnt_reg, dat_i, sel_i);
      end
    end
  end

  // Sticky interrupt status, set wins over write-one clear
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      irqStat_reg <= '0;
      half_reg    <= 1'b0;
      irq         <= 1'b0;
    end else begin
      irqStat_reg <= (irqStat_reg & ~((wrHit && adr_i == OFS_IRQSTAT)
                     ? wrIrq[IRQ_W-1:0] : '0)) | irqEvents;
      half_reg    <= halfFull;
      irq         <= |(irqStat_reg & irqMask_reg);
    end
  end

  // Verdict, recovery records, buffer select and alarm
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pktAccept  <= 1'b0;
      pktDrop    <= 1'b0;
      crAValid   <= 1'b0;
      crBValid   <= 1'b0;
      crSeq      <= '0;
      crTs       <= '0;
      bufIndex   <= '0;
      errorAlarm <= 1'b0;
    end else begin
      pktAccept  <= accept;
      pktDrop    <= pktValid & overMax;  // RQ8
      crAValid   <= accept & selA;  // RQ1
      crBValid   <= accept & selB;  // RQ2
      if (accept) begin
        crSeq <= pktSeq;
        crTs  <= pktTs;
      end
      bufIndex   <= idxField;  // RQ3
      errorAlarm <= halfFull;  // RQ4
    end
  end

  // Checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  logic [FILL_W:0] addExpect;
  assign addExpect = {1'b0, fill_reg} + {1'b0, payLen, {FRAC_SH{1'b0}}};

  chk_rec_a: assert property (pktValid && !overMax && selA |=> // RQ1
      crAValid && crSeq == $past(pktSeq) && crTs == $past(pktTs))
    else $error("recovery A record missing");
  chk_rec_b: assert property (pktValid && !overMax && selB |=> // RQ2
      crBValid && crSeq == $past(pktSeq))
    else $error("recovery B record missing");
  chk_buf_index: assert property (ctrlMaskWr ##2 1'b1 |-> // RQ3
      bufIndex == $past(ctrl_reg[CTRL_IDX_LSB +: IDX_W]))
    else $error("buffer index not forwarded");
  chk_alarm_level: assert property (hfEn && // RQ4
      hostBufLevel > (hostBufCap >> 1) |=> errorAlarm)
    else $error("half full alarm missing");
  chk_fill_drain: assert property (pktValid && payLen == '0 && // RQ5
      frameDelta != '0 && fill_reg != '0 |=> fill_reg < $past(fill_reg))
    else $error("bucket not drained");
  chk_rate_min: assert property (rate_reg == 6'h04 |-> // RQ6
      rate64 == 17'h00004)
    else $error("minimum rate decode wrong");
  chk_drop_over: assert property (pktValid && overMax |=> // RQ8
      pktDrop && !pktAccept && !crAValid && !crBValid)
    else $error("overfull packet not dropped");
  chk_max_zero: assert property (pktValid && max_reg == '0 && // RQ9
      fill_reg == '0 && pktUdpLen == 16'hffff |=> pktAccept)
    else $error("zero maximum not 65536 bytes");
  chk_fill_add: assert property (pktValid && !overMax && // RQ12
      frameDelta == '0 |=> fill_reg == $past(addExpect[FILL_W-1:0]))
    else $error("bucket add wrong");
  chk_last_ts: assert property (pktValid |=> // RQ13
      lastTs_reg == $past(frameCount) && init_reg)  // RQ14
    else $error("frame stamp or init not stored");
  chk_pkt_count: assert property (pktValid |=> // RQ15
      pktCnt_reg == $past(pktCnt_reg) + ONE_COUNT)
    else $error("packet count wrong");
  chk_oct_count: assert property (pktValid |=> // RQ16
      octCnt_reg == $past(octCnt_reg) + DATA_W'($past(payLen)))
    else $error("octet count wrong");
  chk_alarm_off: assert property (!hfEn |=> // RQ4
      !errorAlarm)
    else $error("alarm with enable clear");
  chk_drop_keep: assert property (pktValid && overMax && // RQ8
      frameDelta == '0 |=> fill_reg == $past(fill_reg))
    else $error("dropped packet changed fill");
  chk_rec_none: assert property (!accept |=> // RQ1
      !crAValid && !crBValid)
    else $error("record without accepted packet");
  chk_ack_pulse: assert property (ack_o |=>
      !ack_o)
    else $error("ack held longer than one cycle");

  cov_drop:   cover property (pktValid && overMax ##1 pktDrop);
  cov_rec_a:  cover property (crAValid && crBValid);
  cov_alarm:  cover property (errorAlarm ##1 irq);
  cov_rec_b:  cover property (crBValid && !crAValid);
  cov_half:   cover property ($rose(errorAlarm));
endmodule : rx_cpu_channel_policer

// ===== test/host_buffer_model.sv
// Host receive buffer seen by the channel: fills on accepts, software drains
`timescale 1ns/1ps
module host_buffer_model
  import rx_cpu_policer_pkg::*;
#(
  parameter int CAP   = 64,
  parameter int CHUNK = 20
)
(
  // Clock and reset
  input  wire logic             clk,
  input  wire logic             rst,
  // Channel verdict and software drain
  input  wire logic             pktAccept,
  input  wire logic             drainAll,
  // Buffer state
  output logic      [LEN_W-1:0] hostBufLevel,
  output logic      [LEN_W-1:0] hostBufCap
);
  logic [LEN_W-1:0] level_reg;

  assign hostBufLevel = level_reg;
  assign hostBufCap   = LEN_W'(CAP);

  // Each accepted packet lands in the buffer unless software empties it whole in the same cycle
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      level_reg <= '0;
    end else if (drainAll) begin
      level_reg <= '0;
    end else if (pktAccept) begin
      level_reg <= level_reg + LEN_W'(CHUNK);
    end
  end
endmodule : host_buffer_model

// ===== test/rx_cpu_channel_policer_tb.sv
// Self-checking bench of the receive CPU channel policer
`timescale 1ns/1ps
module rx_cpu_channel_policer_tb
  import rx_cpu_policer_pkg::*;
;
  logic              clk, rst, cyc_i, stb_i, we_i, pktValid, drainAll;
  logic [ADR_W-1:0]  adr_i;
  logic [DATA_W-1:0] dat_i, dat_o, rd;
  logic [SEL_W-1:0]  sel_i;
  logic              ack_o, pktAccept, pktDrop, crAValid, crBValid;
  logic [LEN_W-1:0]  pktUdpLen, hostBufLevel, hostBufCap;
  logic [SEQ_W-1:0]  pktSeq, crSeq, seqNo;
  logic [TS_W-1:0]   pktTs, crTs;
  logic [FRAME_W-1:0] frameCount;
  logic [IDX_W-1:0]  bufIndex;
  logic              errorAlarm, irq;
  int                errCount, testsRun;

  rx_cpu_channel_policer i_dut (.clk(clk), .rst(rst), .cyc_i(cyc_i),
    .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i), .dat_i(dat_i), .sel_i(sel_i),
    .dat_o(dat_o), .ack_o(ack_o), .pktValid(pktValid), .pktUdpLen(pktUdpLen),
    .pktSeq(pktSeq), .pktTs(pktTs), .frameCount(frameCount),
    .hostBufLevel(hostBufLevel), .hostBufCap(hostBufCap),
    .pktAccept(pktAccept), .pktDrop(pktDrop), .bufIndex(bufIndex),
    .crAValid(crAValid), .crBValid(crBValid), .crSeq(crSeq), .crTs(crTs),
    .errorAlarm(errorAlarm), .irq(irq));

  host_buffer_model #(.CAP(64), .CHUNK(20)) i_host (.clk(clk), .rst(rst),
    .pktAccept(pktAccept), .drainAll(drainAll),
    .hostBufLevel(hostBufLevel), .hostBufCap(hostBufCap));

  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  task automatic print_verdict();
    $display("checks %0d mismatches %0d", testsRun, errCount);
    if (errCount == 0 && testsRun > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : print_verdict

  task automatic check(input logic [DATA_W-1:0] seen,
                       input logic [DATA_W-1:0] expv, input string msg);
    testsRun++;
    if (seen !== expv) begin
      errCount++;
      $display("mismatch at %0t: %s seen %h expected %h", $time, msg,
               seen, expv);
    end
  endtask : check

  // Classic single cycle, held until ack is sampled high
  task automatic wb(input logic we, input logic [ADR_W-1:0] a,
                    input logic [DATA_W-1:0] d);
    int n;
    n = 0;
    @(posedge clk);
    cyc_i <= 1'b1;
    stb_i <= 1'b1;
    we_i  <= we;
    adr_i <= a;
    dat_i <= d;
    do begin
      @(posedge clk);
      n++;
    end while (ack_o !== 1'b1 && n < 50);
    if (n >= 50) check(32'h0, 32'h1, "no ack");
    rd = dat_o;
    cyc_i <= 1'b0;
    stb_i <= 1'b0;
    we_i  <= 1'b0;
  endtask : wb

  task automatic rchk(input logic [ADR_W-1:0] a,
                      input logic [DATA_W-1:0] e, input string msg);
    wb(1'b0, a, 32'h0);
    check(rd, e, msg);
  endtask : rchk

  task automatic send(input logic [LEN_W-1:0] len, input logic acc,
                      input logic ea, input logic eb);
    seqNo = seqNo + 16'h0001;
    @(posedge clk);
    pktValid  <= 1'b1;
    pktUdpLen <= len;
    pktSeq    <= seqNo;
    pktTs     <= {seqNo, 16'h5a5a};
    @(posedge clk);
    pktValid <= 1'b0;
    @(posedge clk);
    check({31'h0, pktAccept}, {31'h0, acc}, "accept");
    check({31'h0, pktDrop}, {31'h0, !acc}, "drop");
    check({31'h0, crAValid}, {31'h0, ea}, "queue A");
    check({31'h0, crBValid}, {31'h0, eb}, "queue B");
    if (acc) check({16'h0, crSeq}, {16'h0, seqNo}, "record seq");
    if (acc) check(crTs, {seqNo, 16'h5a5a}, "record ts");
  endtask : send

  initial begin
    repeat (20000) @(posedge clk);
    errCount++;
    print_verdict();
  end

  initial begin
    rst        = 1'b1;
    cyc_i      = 1'b0;
    stb_i      = 1'b0;
    we_i       = 1'b0;
    adr_i      = '0;
    dat_i      = '0;
    sel_i      = 4'hf;
    pktValid   = 1'b0;
    pktUdpLen  = '0;
    pktSeq     = '0;
    pktTs      = '0;
    frameCount = 16'h0100;
    drainAll   = 1'b0;
    seqNo      = '0;
    errCount   = 0;
    testsRun   = 0;
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    rchk(OFS_CTRL, 32'h0, "ctrl reset");
    rchk(OFS_PKTCNT, 32'h0, "count reset");
    rchk(8'h40, 32'h0, "unmapped");
    wb(1'b1, OFS_CTRL, 32'h0005_a307);
    rchk(OFS_CTRL, 32'h0005_a307, "ctrl");
    check({20'h0, bufIndex}, 32'h0000_05a3, "buffer index");
    wb(1'b1, OFS_FILL, 32'h0);
    wb(1'b1, OFS_INIT, 32'h0);
    wb(1'b1, OFS_RATE, 32'h0000_0004);
    wb(1'b1, OFS_MAXFILL, 32'h0000_0001);
    send(16'h0009, 1'b1, 1'b1, 1'b1);
    rchk(OFS_INIT, 32'h1, "init set");
    rchk(OFS_FILL, 32'h40, "fill one byte");
    rchk(OFS_LASTTS, 32'h0100, "last frame");
    send(16'h0009, 1'b0, 1'b0, 1'b0);
    rchk(OFS_FILL, 32'h40, "fill after drop");
    frameCount <= frameCount + 16'h0010;
    send(16'h0009, 1'b1, 1'b1, 1'b1);
    rchk(OFS_FILL, 32'h40, "fill drained");
    rchk(OFS_LASTTS, 32'h0110, "last frame 2");
    frameCount <= frameCount + 16'h0008;
    send(16'h0008, 1'b1, 1'b1, 1'b1);
    rchk(OFS_FILL, 32'h20, "half drain");
    wb(1'b1, OFS_RATE, 32'h0000_000f);
    frameCount <= frameCount + 16'h0001;
    send(16'h0004, 1'b1, 1'b1, 1'b1);
    rchk(OFS_FILL, 32'h04, "fast rate");
    rchk(OFS_PKTCNT, 32'h5, "packets");
    rchk(OFS_OCTCNT, 32'h3, "octets");
    wb(1'b1, OFS_MAXFILL, 32'h0);
    wb(1'b1, OFS_FILL, 32'h003f_ffc0);
    send(16'h0009, 1'b1, 1'b1, 1'b1);
    send(16'h0009, 1'b0, 1'b0, 1'b0);
    rchk(OFS_FILL, 32'h0040_0000, "full bucket");
    wb(1'b1, OFS_IRQMASK, 32'h1);
    wb(1'b1, OFS_IRQSTAT, 32'hffff_ffff);
    repeat (2) @(posedge clk);
    check({31'h0, irq}, 32'h0, "irq cleared");
    send(16'h0009, 1'b0, 1'b0, 1'b0);
    repeat (2) @(posedge clk);
    check({31'h0, irq}, 32'h1, "irq raised");
    rchk(OFS_IRQSTAT, 32'h1, "drop status");
    wb(1'b1, OFS_IRQMASK, 32'h0);
    repeat (2) @(posedge clk);
    check({31'h0, irq}, 32'h0, "irq masked");
    wb(1'b1, OFS_FILL, 32'h0);
    send(16'hffff, 1'b1, 1'b1, 1'b1);
    rchk(OFS_FILL, 32'h003f_fdc0, "large packet");
    @(posedge clk);
    drainAll <= 1'b1;
    @(posedge clk);
    drainAll <= 1'b0;
    send(16'h0009, 1'b1, 1'b1, 1'b1);
    repeat (2) @(posedge clk);
    check({31'h0, errorAlarm}, 32'h0, "alarm below half");
    send(16'h0009, 1'b1, 1'b1, 1'b1);
    repeat (2) @(posedge clk);
    check({31'h0, errorAlarm}, 32'h1, "alarm over half");
    wb(1'b1, OFS_CTRL, 32'h0005_a303);
    repeat (2) @(posedge clk);
    check({31'h0, errorAlarm}, 32'h0, "alarm disabled");
    wb(1'b1, OFS_CTRL, 32'h0005_a301);
    send(16'h0009, 1'b1, 1'b1, 1'b0);
    wb(1'b1, OFS_CTRL, 32'h0005_a302);
    send(16'h0009, 1'b1, 1'b0, 1'b1);
    print_verdict();
  end
endmodule : rx_cpu_channel_policer_tb
